// ==== inc/flash_protect_consts.vh ====
`ifndef FLASH_PROTECT_CONSTS_VH
`define FLASH_PROTECT_CONSTS_VH

// ************************************************************
// register select codes on the command port
// ************************************************************
`define REG_BANK      4'h0
`define REG_MODE      4'h1
`define REG_PASS      4'h2
`define REG_PERSISTENT_BIT_LOCK      4'h3
`define REG_PPB       4'h4
`define REG_PPB_ERASE 4'h5
`define REG_DYB       4'h6
`define REG_NVDL      4'h7
`define REG_VDL       4'h8

// ************************************************************
// field positions
// ************************************************************
`define BANK_FOUR_BYTE_BIT 7
`define BANK_LOW_BIT       0
`define MODE_PWD_LOCK_BIT  2
`define MODE_PST_LOCK_BIT  1
`define FREEZE_BIT         0
`define ADDR_LOW_MSB       23

// ************************************************************
// reset and shipped values
// ************************************************************
`define MODE_SHIPPED    16'hfe7f
`define PASS_SHIPPED    64'hffffffffffffffff
`define PATTERN_SHIPPED 8'h00
`define SECTOR_OPEN     8'hff
`define SECTOR_GUARDED  8'h00
`define FREEZE_OPEN     1'b1

`endif

// ==== hdl/flash_protect_addr_regs.v ====
// Overview of operation
// - extended bit set: full four-byte command address
// - extended bit clear: three bytes plus bank bits
// - bank low bit is address bit 24
// - password lock at 0 fixes password mode
// - persistent lock at 0 fixes persistent mode
// - 64-bit password, hidden once password mode
// - freeze bit 0 refuses persistent bit changes
// - freeze bit set after reset outside password mode, cleared in it, upper zero
// - dynamic access 00h guards, FFh opens, reset FFh
// - working pattern loaded from stored at reset
`timescale 1ns/10ps
`default_nettype none
`include "flash_protect_consts.vh"

module flash_protect_addr_regs #(
  parameter [0:0] big_density = 1'b1, // 1: bank low bit drives address bit 24
  parameter nsect = 512,              // number of protection sectors
  parameter sect_w = 9                // width of a sector index
) (
  input wire clk,                      // system clock
  input wire srst,                     // hardware reset, synchronous
  input wire nv_init,                  // loads shipped non-volatile contents
  input wire cmd_valid,                // register command strobe
  input wire cmd_write,                // 1 write or program, 0 read
  input wire [3:0] cmd_reg,            // register select
  input wire [sect_w-1:0] cmd_sector,  // sector for per-sector access
  input wire [63:0] cmd_wdata,         // write data, low bits used
  input wire [31:0] cmd_addr,          // address taken from a command
  input wire [sect_w-1:0] query_sector, // sector asked about by the array
  output reg [63:0] rsp_rdata,         // read answer
  output reg rsp_valid,                // read answer strobe
  output reg cmd_refused,              // write was refused
  output reg [31:0] mem_addr,          // formed memory address
  output reg four_byte_addr_enable,    // extended address mode
  output reg sector_protected,         // query_sector is guarded
  output reg password_mode,            // password mode fixed
  output reg persistent_mode,          // persistent mode fixed
  output reg [7:0] training_pattern,   // working pattern for ddr latency
  output reg training_enable           // pattern delivery enabled
);

  // ************************************************************
  // storage
  // ************************************************************
  reg bank_bit_low;
  reg [15:0] protection_mode_select;
  reg [63:0] password_value;
  reg persistent_bits_freeze;
  reg [7:0] stored_pattern;
  reg [63:0] next_rdata;
  wire [nsect-1:0] persistent_sector_bit;
  wire [nsect-1:0] dynamic_sector_bit;

  // ************************************************************
  // command decode
  // ************************************************************
  wire wr;
  wire rd;
  wire bank_wr;
  wire mode_wr;
  wire pass_wr;
  wire freeze_wr;
  wire ppb_wr;
  wire ppb_erase;
  wire dyb_wr;
  wire nvdl_wr;
  wire vdl_wr;
  wire pass_locked;
  wire ppb_change_ok;
  wire ppb_refuse;
  wire pass_refuse;

  // strobes qualified by the select code
  assign wr = cmd_valid & cmd_write;
  assign rd = cmd_valid & ~cmd_write;
  assign bank_wr = wr & (cmd_reg == `REG_BANK);
  assign mode_wr = wr & (cmd_reg == `REG_MODE);
  assign pass_wr = wr & (cmd_reg == `REG_PASS);
  assign freeze_wr = wr & (cmd_reg == `REG_PERSISTENT_BIT_LOCK);
  assign ppb_wr = wr & (cmd_reg == `REG_PPB);
  assign ppb_erase = wr & (cmd_reg == `REG_PPB_ERASE);
  assign dyb_wr = wr & (cmd_reg == `REG_DYB);
  assign nvdl_wr = wr & (cmd_reg == `REG_NVDL);
  assign vdl_wr = wr & (cmd_reg == `REG_VDL);

  // password mode is chosen when its lock bit has been programmed low
  assign pass_locked = ~protection_mode_select[`MODE_PWD_LOCK_BIT];

  // persistent bits may change only while the freeze bit is high
  assign ppb_change_ok = persistent_bits_freeze;
  assign ppb_refuse = (ppb_wr | ppb_erase) & ~ppb_change_ok;

  // once hidden, the password is no longer programmable either
  assign pass_refuse = pass_wr & pass_locked;

  // ************************************************************
  // bank register and address forming
  // ************************************************************

  // volatile bank bits clear on reset; bits 6..1 are reserved
  always @(posedge clk) begin
    if (srst) begin
      four_byte_addr_enable <= 1'b0;
      bank_bit_low <= 1'b0;
    end else if (bank_wr) begin
      four_byte_addr_enable <= cmd_wdata[`BANK_FOUR_BYTE_BIT];
      bank_bit_low <= cmd_wdata[`BANK_LOW_BIT] & big_density;
    end
  end

  // address formed one cycle after cmd_addr is presented
  always @(posedge clk) begin
    if (srst) begin
      mem_addr <= 32'h0;
    end else if (four_byte_addr_enable) begin
      mem_addr <= cmd_addr;
    end else begin
      mem_addr <= {7'h0, bank_bit_low, cmd_addr[`ADDR_LOW_MSB:0]};
    end
  end

  // ************************************************************
  // one-time-programmable mode, password and stored pattern
  // ************************************************************

  // programming can only clear bits, so a lock once low stays low
  always @(posedge clk) begin
    if (nv_init) begin
      protection_mode_select <= `MODE_SHIPPED;
    end else if (mode_wr) begin
      protection_mode_select <= protection_mode_select & cmd_wdata[15:0];
    end
  end

  // mode outputs follow the lock bits one cycle later
  always @(posedge clk) begin
    if (srst) begin
      password_mode <= 1'b0;
      persistent_mode <= 1'b0;
    end else begin
      password_mode <= pass_locked;
      persistent_mode <= ~protection_mode_select[`MODE_PST_LOCK_BIT];
    end
  end

  // password bits program from 1 to 0 only
  always @(posedge clk) begin
    if (nv_init) begin
      password_value <= `PASS_SHIPPED;
    end else if (pass_wr & ~pass_locked) begin
      password_value <= password_value & cmd_wdata;
    end
  end

  // stored pattern ships as 00h, so programming sets bits
  always @(posedge clk) begin
    if (nv_init) begin
      stored_pattern <= `PATTERN_SHIPPED;
    end else if (nvdl_wr) begin
      stored_pattern <= stored_pattern | cmd_wdata[7:0];
    end
  end

  // ************************************************************
  // persistent bit freeze
  // ************************************************************

  // reset reopens the array in persistent mode; software can only clear
  // the freeze bit, since only a reset outside password mode sets it again
  always @(posedge clk) begin
    if (srst) begin
      persistent_bits_freeze <= pass_locked ? ~`FREEZE_OPEN : `FREEZE_OPEN;
    end else if (freeze_wr) begin
      persistent_bits_freeze <= persistent_bits_freeze & cmd_wdata[`FREEZE_BIT];
    end
  end

  // ************************************************************
  // per-sector protection bits
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < nsect; g = g + 1) begin : g_sect
      localparam [sect_w-1:0] idx = g;
      reg ppb_q;
      reg dyb_q;

      // non-volatile bit: program guards one sector, erase opens all
      always @(posedge clk) begin
        if (nv_init) begin
          ppb_q <= 1'b1;
        end else if (ppb_erase & ppb_change_ok) begin
          ppb_q <= 1'b1;
        end else if (ppb_wr & ppb_change_ok & (cmd_sector == idx)) begin
          // programming only clears; other data leaves the bit as it was
          ppb_q <= ppb_q & (cmd_wdata[7:0] != `SECTOR_GUARDED);
        end
      end

      // volatile bit: any value other than FFh guards the sector
      always @(posedge clk) begin
        if (srst) begin
          dyb_q <= 1'b1;
        end else if (dyb_wr & (cmd_sector == idx)) begin
          dyb_q <= (cmd_wdata[7:0] == `SECTOR_OPEN);
        end
      end

      assign persistent_sector_bit[g] = ppb_q;
      assign dynamic_sector_bit[g] = dyb_q;
    end
  endgenerate

  // either bit low guards the sector against program and erase
  always @(posedge clk) begin
    if (srst) begin
      sector_protected <= 1'b0;
    end else begin
      sector_protected <= ~persistent_sector_bit[query_sector] |
                          ~dynamic_sector_bit[query_sector];
    end
  end

  // ************************************************************
  // training pattern
  // ************************************************************

  // reset copies the stored pattern; the host may overwrite it later
  always @(posedge clk) begin
    if (srst) begin
      training_pattern <= stored_pattern;
    end else if (vdl_wr) begin
      training_pattern <= cmd_wdata[7:0];
    end
  end

  // an all-zero pattern means no pattern is driven
  always @(posedge clk) begin
    if (srst) begin
      training_enable <= 1'b0;
    end else begin
      training_enable <= (training_pattern != `PATTERN_SHIPPED);
    end
  end

  // ************************************************************
  // read path
  // ************************************************************

  // read data mux; reserved bits and unknown selects read zero
  always @* begin
    next_rdata = 64'h0;
    case (cmd_reg)
      `REG_BANK: begin
        next_rdata[`BANK_FOUR_BYTE_BIT] = four_byte_addr_enable;
        next_rdata[`BANK_LOW_BIT] = bank_bit_low;
      end
      `REG_MODE: begin
        next_rdata[15:0] = protection_mode_select;
      end
      `REG_PASS: begin
        next_rdata = pass_locked ? 64'h0 : password_value;
      end
      `REG_PERSISTENT_BIT_LOCK: begin
        next_rdata[`FREEZE_BIT] = persistent_bits_freeze;
      end
      `REG_PPB: begin
        next_rdata[7:0] = {8{persistent_sector_bit[cmd_sector]}};
      end
      `REG_DYB: begin
        next_rdata[7:0] = {8{dynamic_sector_bit[cmd_sector]}};
      end
      `REG_NVDL: begin
        next_rdata[7:0] = stored_pattern;
      end
      `REG_VDL: begin
        next_rdata[7:0] = training_pattern;
      end
      default: begin
        next_rdata = 64'h0;
      end
    endcase
  end

  // answer registered one cycle after the read strobe, held until next read
  always @(posedge clk) begin
    if (srst) begin
      rsp_rdata <= 64'h0;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= rd;
      if (rd) begin
        rsp_rdata <= next_rdata;
      end
    end
  end

  // refusal shows as a one-cycle pulse after the write
  always @(posedge clk) begin
    if (srst) begin
      cmd_refused <= 1'b0;
    end else begin
      cmd_refused <= ppb_refuse | pass_refuse;
    end
  end

endmodule // flash_protect_addr_regs

`default_nettype wire

// ==== dv/prot_regs_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "flash_protect_consts.vh"
// ****
// port checker
// ****
module prot_regs_monitor (
  input wire logic clk, // system clock
  input wire logic srst, // hardware reset
  input wire logic cmd_valid, // command strobe
  input wire logic cmd_write, // write flag
  input wire logic [3:0] cmd_reg, // register select
  input wire logic [63:0] cmd_wdata, // write data
  input wire logic [31:0] cmd_addr, // command address
  input wire logic [63:0] rsp_rdata, // read answer
  input wire logic rsp_valid, // answer strobe
  input wire logic cmd_refused, // refusal pulse
  input wire logic [31:0] mem_addr, // formed address
  input wire logic four_byte_addr_enable, // extended mode
  input wire logic password_mode, // password mode fixed
  input wire logic persistent_mode, // persistent mode fixed
  input wire logic [7:0] training_pattern // working pattern
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // read strobe, kept apart so $past sees one signal
  wire logic rd = cmd_valid && !cmd_write;
  a_read_answered: assert property (rd |=> rsp_valid) else $error("read not answered");
  a_no_stray_answer: assert property (rsp_valid |-> $past(rd)) else $error("stray answer");
  // address is checked only once the previous edge was out of reset
  a_full_address: assert property (!$past(srst) && $past(four_byte_addr_enable) |->
    mem_addr == $past(cmd_addr)) else $error("four byte address wrong");
  a_bank_address: assert property (!$past(srst) && !$past(four_byte_addr_enable) |->
    mem_addr[31:25] == 7'h00 && mem_addr[23:0] == $past(cmd_addr[23:0]))
    else $error("three byte address wrong");
  a_password_kept: assert property (password_mode |=> password_mode) else $error("left password");
  a_persist_kept: assert property (persistent_mode |=> persistent_mode) else $error("left mode");
  a_password_hidden: assert property (rd && cmd_reg == `REG_PASS && password_mode |=>
    rsp_rdata == 64'h0) else $error("password shown");
  a_pattern_write: assert property (cmd_valid && cmd_write && cmd_reg == `REG_VDL |=>
    training_pattern == $past(cmd_wdata[7:0])) else $error("pattern not taken");
  a_refuse_cause: assert property (cmd_refused |-> $past(cmd_valid) && $past(cmd_write))
    else $error("refusal without write");
  c_hidden: cover property (rd && password_mode);
  c_refused: cover property (cmd_refused);
  c_four_byte: cover property (four_byte_addr_enable && cmd_valid);
endmodule // prot_regs_monitor
bind flash_protect_addr_regs prot_regs_monitor i_mon (.clk, .srst, .cmd_valid, .cmd_write,
  .cmd_reg, .cmd_wdata, .cmd_addr, .rsp_rdata, .rsp_valid, .cmd_refused, .mem_addr,
  .four_byte_addr_enable, .password_mode, .persistent_mode, .training_pattern);
`default_nettype wire

// ==== dv/host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****
// host controller side of the register port
// ****
module host_model (
  input wire logic clk, // system clock
  input wire logic [63:0] rsp_rdata, // read answer
  input wire logic cmd_refused, // refusal pulse
  output logic cmd_valid, // command strobe
  output logic cmd_write, // write flag
  output logic [3:0] cmd_reg, // register select
  output logic [8:0] cmd_sector, // sector index
  output logic [63:0] cmd_wdata // write data
);
  initial {cmd_valid, cmd_write, cmd_reg, cmd_sector, cmd_wdata} = '0;
  // one-cycle strobe; idle select and data are inverted so stale values never look valid
  task automatic issue(input logic w, input logic [3:0] r, input logic [8:0] s,
      input logic [63:0] d, output logic [63:0] q, output logic rf);
    @(posedge clk);
    #1 {cmd_valid, cmd_write, cmd_reg, cmd_sector, cmd_wdata} = {1'b1, w, r, s, d};
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    {cmd_reg, cmd_wdata} = ~{cmd_reg, cmd_wdata};
    rf = cmd_refused;
    @(posedge clk);
    q = rsp_rdata;
    #1;
  endtask
endmodule // host_model
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "flash_protect_consts.vh"
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic nv_init = 1'b1;
  logic [31:0] cmd_addr = 32'h0;
  logic [8:0] query_sector = 9'h0;
  logic [63:0] q;
  logic rf;
  logic [7:0] wd;
  int bad_count = 0;
  int check_count = 0;
  logic [3:0] rs [5] = '{`REG_DYB, `REG_PPB, `REG_PERSISTENT_BIT_LOCK, `REG_NVDL, `REG_VDL};
  logic [7:0] rx [5] = '{8'hff, 8'hff, 8'h01, 8'h00, 8'h00};
  wire cmd_valid, cmd_write, rsp_valid, cmd_refused, four_byte_addr_enable;
  wire sector_protected, password_mode, persistent_mode, training_enable;
  wire [3:0] cmd_reg;
  wire [8:0] cmd_sector;
  wire [63:0] cmd_wdata, rsp_rdata;
  wire [31:0] mem_addr;
  wire [7:0] training_pattern;
  always #5 clk = ~clk;
  flash_protect_addr_regs i_dut (.clk, .srst, .nv_init, .cmd_valid, .cmd_write, .cmd_reg,
    .cmd_sector, .cmd_wdata, .cmd_addr, .query_sector, .rsp_rdata, .rsp_valid, .cmd_refused,
    .mem_addr, .four_byte_addr_enable, .sector_protected, .password_mode, .persistent_mode,
    .training_pattern, .training_enable);
  host_model i_host (.clk, .rsp_rdata, .cmd_refused, .cmd_valid, .cmd_write, .cmd_reg,
    .cmd_sector, .cmd_wdata);
  task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [31:0] addr_exp(input logic [7:0] b, input logic [31:0] a);
    return b[7] ? a : {7'h0, b[0], a[23:0]};
  endfunction
  task automatic wr(input logic [3:0] r, input logic [8:0] s, input logic [63:0] d);
    i_host.issue(1'b1, r, s, d, q, rf);
  endtask
  task automatic rd(input logic [3:0] r, input logic [8:0] s);
    logic x;
    i_host.issue(1'b0, r, s, 64'h0, q, x);
  endtask
  // reset, then let the registered outputs settle
  task automatic do_reset;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // write a per-sector value, read it back, ask about the guard
  task automatic step(input logic [3:0] w, input logic [7:0] d, input logic [7:0] e,
      input logic g);
    wr(w, query_sector, {56'h0, d});
    rd((w == `REG_DYB) ? `REG_DYB : `REG_PPB, query_sector);
    check("sector byte", q, {56'h0, e});
    check("guard", sector_protected, g);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog: the run needs well under a thousand cycles
  initial begin
    #50000;
    bad_count++;
    wrap_up;
  end
  initial begin
    wd = 8'($urandom(32'hefda61d5));
    repeat (2) @(posedge clk);
    #1 {srst, nv_init} = 2'b00;
    foreach (rs[i]) begin
      rd(rs[i], 9'($urandom));
      check("reset value", q, {56'h0, rx[i]});
    end
    $display("test reset done");
    // both address modes; reserved bank bits must not stick
    for (int k = 0; k < 8; k++) begin
      wd = (k == 0) ? 8'h80 : (k == 1) ? 8'h7f : 8'($urandom);
      wr(`REG_BANK, 9'h0, {56'h0, wd});
      rd(`REG_BANK, 9'h0);
      check("bank", q, {56'h0, wd & 8'h81});
      check("four byte", four_byte_addr_enable, wd[7]);
      cmd_addr = (k < 2) ? 32'hffffffff : $urandom;
      @(posedge clk);
      #1 check("mem_addr", mem_addr, addr_exp(wd, cmd_addr));
    end
    $display("test address done");
    query_sector = 9'($urandom);
    step(`REG_DYB, 8'h00, 8'h00, 1'b1);
    step(`REG_DYB, 8'hff, 8'hff, 1'b0);
    step(`REG_PPB, 8'h00, 8'h00, 1'b1);
    step(`REG_PPB_ERASE, 8'h00, 8'hff, 1'b0);
    wr(`REG_PERSISTENT_BIT_LOCK, 9'h0, 64'h0);
    step(`REG_PPB, 8'h00, 8'hff, 1'b0);
    check("refused", rf, 1'b1);
    do_reset;
    rd(`REG_PERSISTENT_BIT_LOCK, 9'h0);
    check("freeze reset", q, 64'h1);
    step(`REG_PPB, 8'h00, 8'h00, 1'b1);
    step(`REG_PPB, 8'hff, 8'h00, 1'b1);
    $display("test sectors done");
    wd = 8'($urandom) | 8'h01;
    wr(`REG_NVDL, 9'h0, {56'h0, wd});
    do_reset;
    check("pattern load", training_pattern, wd);
    check("pattern on", training_enable, 1'b1);
    wd = 8'($urandom);
    wr(`REG_VDL, 9'h0, {56'h0, wd});
    rd(`REG_VDL, 9'h0);
    check("pattern rewrite", q, {56'h0, wd});
    check("pattern out", training_pattern, wd);
    $display("test pattern done");
    rd(`REG_PASS, 9'h0);
    check("password open", q, 64'hffffffffffffffff);
    wr(`REG_MODE, 9'h0, ~64'h2);
    check("persistent mode", persistent_mode, 1'b1);
    check("password mode", password_mode, 1'b0);
    wr(`REG_MODE, 9'h0, ~64'h4);
    do_reset;
    check("password kept", password_mode, 1'b1);
    rd(`REG_PERSISTENT_BIT_LOCK, 9'h0);
    check("freeze in password mode", q, 64'h0);
    rd(`REG_PASS, 9'h0);
    check("password hidden", q, 64'h0);
    wr(`REG_PASS, 9'h0, 64'h0);
    check("password refused", rf, 1'b1);
    rd(`REG_MODE, 9'h0);
    check("mode", q, 64'hfe79);
    $display("test modes done");
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
